// [design/crbd_core.sv]
// decoder and cycle sequencer for register/memory and relative branch groups
//
// What this block does
// - sbc decodes A2..F2 with mode lengths, cycles
// - adc decodes A9..F9 with 2/3/4/5/4/3 cycles
// - eor decodes A8..F8 across six modes
// - compare updates flags, never the accumulator
// - bit test sets flags, no writeback
// - opcode 28 branches when half carry clear
// - opcode 29 branches when half carry set
// - opcode 2C branches when mask clear
// - opcode 2D branches when mask set
// - opcode 2E branches when irq pin low
// - opcode 2F branches when irq pin high
// - opcode 23 branches when carry or zero
// - opcode 24 branches when carry clear
// - higher-or-same shares opcode 24
// - untaken branch acts as no-operation
// - half carry from bit 3 on add
`timescale 1ns/1ps
`include "crbd_defines.svh"
module crbd_core #(
  parameter int unsigned AW = 16  // address width
) (
  input  wire logic          clk_sys,   // 25 MHz clock
  input  wire logic          arst_n,    // async reset, active low
  input  wire logic          clkEn,     // freezes all state except the reset synchroniser when low
  input  wire logic          irqPin,    // external interrupt input level
  input  wire logic [4:0]    ccrInit,   // flags loaded at reset release
  input  wire logic [AW-1:0] pcInit,    // start address after reset
  input  wire logic [7:0]    memRdata,  // memory read data
  input  wire logic [7:0]    idxReg,    // index register value
  output logic [AW-1:0]      memAddr,   // memory address
  output logic               memRd,     // memory read strobe
  output logic [7:0]         accOut,    // accumulator
  output logic [4:0]         ccrOut,    // condition code flags
  output logic [AW-1:0]      pcOut,     // program counter
  output logic               instDone,  // one-cycle pulse at instruction end
  output logic               illegalOp  // opcode outside this block's groups
);
  // reset release through two flops
  logic rstSync1_q;  // first synchroniser stage
  logic rstSync2_q;  // released reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire logic rstN = rstSync2_q;  // internal reset

  crbd_pkg::crbd_state_t state_q, state_d;  // sequencer state
  logic [7:0]    opcode_q, opcode_d;    // current opcode
  logic [7:0]    opnd1_q, opnd1_d;      // first operand byte
  logic [7:0]    opnd2_q, opnd2_d;      // second operand byte
  logic [2:0]    cycCnt_q, cycCnt_d;    // cycles used so far
  logic [AW-1:0] pc_q, pc_d;            // program counter
  logic [AW-1:0] addr_q, addr_d;        // address register
  logic          rd_q, rd_d;            // read strobe register
  logic [7:0]    acc_q, acc_d;          // accumulator
  logic [4:0]    ccr_q, ccr_d;          // flags
  logic          done_q, done_d;        // end pulse
  logic          ill_q, ill_d;          // illegal flag
  logic          init_q, init_d;        // flags and pc loaded

  crbd_pkg::crbd_alu_t decAlu;  // decoded op for fetched byte
  logic [1:0]    decLen;      // decoded length
  logic [2:0]    decCyc;      // decoded cycles
  logic          decBr;       // decoded branch
  logic          decLegal;    // decoded legal
  crbd_pkg::crbd_alu_t curAlu;  // op of latched opcode
  logic [1:0]    curLen;      // latched length
  logic [2:0]    curCyc;      // latched cycles
  logic          curBr;       // latched branch
  logic [7:0]    aluRes;      // alu result
  logic          aluWr;       // alu writes acc
  logic          aluH;        // half carry
  logic          aluHUpd;     // half carry updated
  logic          aluC;        // carry
  logic          aluCUpd;     // carry updated
  logic          commitNow;   // instruction ends on this edge

  // decode of the byte on the bus during fetch
  crbd_opdecode uDecFetch (
    .opcode   (memRdata),
    .aluOp    (decAlu),
    .opLen    (decLen),
    .opCyc    (decCyc),
    .isBranch (decBr),
    .legal    (decLegal)
  );
  // decode of the latched opcode for later cycles
  crbd_opdecode uDecCur (
    .opcode   (opcode_q),
    .aluOp    (curAlu),
    .opLen    (curLen),
    .opCyc    (curCyc),
    .isBranch (curBr),
    .legal    ()
  );
  crbd_alu uAlu (
    .aluOp    (curAlu),
    .accIn    (acc_q),
    .memIn    (memRdata),
    .carryIn  (ccr_q[`CRBD_CCR_C]),
    .result   (aluRes),
    .writeAcc (aluWr),
    .halfOut  (aluH),
    .halfUpd  (aluHUpd),
    .carryOut (aluC),
    .carryUpd (aluCUpd)
  );

  // branch condition from flags and interrupt pin
  function automatic logic brTaken(input logic [3:0] cond, input logic [4:0] ccr,
                                   input logic pin);
    logic t;
    t = 1'b0;
    unique case (cond)
      `CRBD_BR_HI:  t = !(ccr[`CRBD_CCR_C] | ccr[`CRBD_CCR_Z]);
      `CRBD_BR_LS:  t = ccr[`CRBD_CCR_C] | ccr[`CRBD_CCR_Z];
      `CRBD_BR_CC:  t = !ccr[`CRBD_CCR_C];
      `CRBD_BR_HCC: t = !ccr[`CRBD_CCR_H];
      `CRBD_BR_HCS: t = ccr[`CRBD_CCR_H];
      `CRBD_BR_MC:  t = !ccr[`CRBD_CCR_I];
      `CRBD_BR_MS:  t = ccr[`CRBD_CCR_I];
      `CRBD_BR_IL:  t = !pin;
      `CRBD_BR_IH:  t = pin;
      default:      t = 1'b0;
    endcase
    return t;
  endfunction

  // effective operand address for the memory modes
  function automatic logic [AW-1:0] effAddr(input logic [3:0] mode, input logic [7:0] b1,
                                            input logic [7:0] b2, input logic [7:0] x);
    logic [AW-1:0] a;
    a = '0;
    unique case (mode)
      `CRBD_MODE_DIR: a = AW'(b1);
      `CRBD_MODE_EXT: a = AW'({b1, b2});
      `CRBD_MODE_IX:  a = AW'(x);
      `CRBD_MODE_IX1: a = AW'({8'h00, b1} + {8'h00, x});
      `CRBD_MODE_IX2: a = AW'({b1, b2} + {8'h00, x});
      default:        a = '0;
    endcase
    return a;
  endfunction

  // next-state logic for sequencer and programmer's state
  always_comb begin
    state_d  = state_q;
    opcode_d = opcode_q;
    opnd1_d  = opnd1_q;
    opnd2_d  = opnd2_q;
    cycCnt_d = cycCnt_q;
    pc_d     = pc_q;
    addr_d   = addr_q;
    rd_d     = 1'b0;
    acc_d    = acc_q;
    ccr_d    = ccr_q;
    done_d   = 1'b0;
    ill_d    = ill_q;
    init_d   = 1'b1;
    commitNow = 1'b0;
    if (!init_q) begin
      // first enabled cycle after release: load start values
      ccr_d   = ccrInit;
      pc_d    = pcInit;
      addr_d  = pcInit;
      rd_d    = 1'b1;
      state_d = crbd_pkg::ST_FETCH;
    end else begin
      unique case (state_q)
        crbd_pkg::ST_FETCH: begin
          // opcode on the bus, decode length and cycles
          opcode_d = memRdata;
          cycCnt_d = 3'h1;
          if (!decLegal) begin
            ill_d   = 1'b1;
            state_d = crbd_pkg::ST_TRAP;
          end else if (decLen == 2'h1) begin
            // no-offset indexed: read operand at x
            pc_d    = pc_q + AW'(1);
            addr_d  = AW'(idxReg);
            rd_d    = 1'b1;
            state_d = crbd_pkg::ST_WAIT;
          end else begin
            pc_d    = pc_q + AW'(1);
            addr_d  = pc_q + AW'(1);
            rd_d    = 1'b1;
            state_d = crbd_pkg::ST_OPND1;
          end
        end
        crbd_pkg::ST_OPND1: begin
          // first operand byte
          opnd1_d  = memRdata;
          pc_d     = pc_q + AW'(1);
          cycCnt_d = cycCnt_q + 3'h1;
          if (curBr) begin
            state_d = crbd_pkg::ST_EXEC;
          end else if (curLen == 2'h3) begin
            addr_d  = pc_q + AW'(1);
            rd_d    = 1'b1;
            state_d = crbd_pkg::ST_OPND2;
          end else if (opcode_q[7:4] == `CRBD_MODE_IMM) begin
            commitNow = 1'b1; // immediate operand is on the bus now
          end else begin
            addr_d  = effAddr(opcode_q[7:4], memRdata, 8'h00, idxReg);
            rd_d    = 1'b1;
            state_d = crbd_pkg::ST_WAIT;
          end
        end
        crbd_pkg::ST_OPND2: begin
          // second operand byte, form 16-bit address
          opnd2_d  = memRdata;
          pc_d     = pc_q + AW'(1);
          cycCnt_d = cycCnt_q + 3'h1;
          addr_d   = effAddr(opcode_q[7:4], opnd1_q, memRdata, idxReg);
          rd_d     = 1'b1;
          state_d  = crbd_pkg::ST_WAIT;
        end
        crbd_pkg::ST_WAIT: begin
          // operand held on the bus until the cycle count is used up
          cycCnt_d  = cycCnt_q + 3'h1;
          rd_d      = 1'b1;
          commitNow = (cycCnt_q + 3'h1 >= curCyc);
        end
        crbd_pkg::ST_EXEC: begin
          // branch decision in its last cycle
          cycCnt_d = cycCnt_q + 3'h1;
          if (cycCnt_q + 3'h1 >= curCyc) begin
            commitNow = 1'b1;
            if (brTaken(opcode_q[3:0], ccr_q, irqPin)) begin
              pc_d = pc_q + AW'({{8{opnd1_q[7]}}, opnd1_q});
            end
            // untaken: pc already at next instruction
          end
        end
        crbd_pkg::ST_TRAP: state_d = crbd_pkg::ST_TRAP; // held until reset
        default: state_d = crbd_pkg::ST_TRAP;
      endcase
      if (commitNow) begin
        // commit while the operand is live, then fetch from the new pc
        if (!curBr) begin
          if (aluWr) begin
            acc_d = aluRes;
          end
          ccr_d[`CRBD_CCR_N] = aluRes[7];
          ccr_d[`CRBD_CCR_Z] = (aluRes == 8'h00);
          if (aluCUpd) begin
            ccr_d[`CRBD_CCR_C] = aluC;
          end
          if (aluHUpd) begin
            ccr_d[`CRBD_CCR_H] = aluH;
          end
        end
        addr_d  = pc_d;
        rd_d    = 1'b1;
        done_d  = 1'b1;
        state_d = crbd_pkg::ST_FETCH;
      end
    end
  end

  // state registers, frozen while the enable is low
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_q  <= crbd_pkg::ST_FETCH;
      opcode_q <= 8'h00;
      opnd1_q  <= 8'h00;
      opnd2_q  <= 8'h00;
      cycCnt_q <= 3'h0;
      pc_q     <= '0;
      addr_q   <= '0;
      rd_q     <= 1'b0;
      acc_q    <= 8'h00;
      ccr_q    <= `CRBD_CCR_RST;
      done_q   <= 1'b0;
      ill_q    <= 1'b0;
      init_q   <= 1'b0;
    end else if (clkEn) begin
      state_q  <= state_d;
      opcode_q <= opcode_d;
      opnd1_q  <= opnd1_d;
      opnd2_q  <= opnd2_d;
      cycCnt_q <= cycCnt_d;
      pc_q     <= pc_d;
      addr_q   <= addr_d;
      rd_q     <= rd_d;
      acc_q    <= acc_d;
      ccr_q    <= ccr_d;
      done_q   <= done_d;
      ill_q    <= ill_d;
      init_q   <= init_d;
    end
  end

  // outputs straight from flops
  assign memAddr   = addr_q;
  assign memRd     = rd_q;
  assign accOut    = acc_q;
  assign ccrOut    = ccr_q;
  assign pcOut     = pc_q;
  assign instDone  = done_q;
  assign illegalOp = ill_q;
endmodule

// [design/crbd_defines.svh]
// opcode, mode, flag position and timing constants for the decoder
`ifndef CRBD_DEFINES_SVH
`define CRBD_DEFINES_SVH
`define CRBD_OP_SBC_LO    4'h2
`define CRBD_OP_CMP_LO    4'h1
`define CRBD_OP_BIT_LO    4'h5
`define CRBD_OP_EOR_LO    4'h8
`define CRBD_OP_ADC_LO    4'h9
`define CRBD_OP_ADD_LO    4'hb
`define CRBD_MODE_IMM     4'ha
`define CRBD_MODE_DIR     4'hb
`define CRBD_MODE_EXT     4'hc
`define CRBD_MODE_IX2     4'hd
`define CRBD_MODE_IX1     4'he
`define CRBD_MODE_IX      4'hf
`define CRBD_BR_HI        4'h2
`define CRBD_BR_LS        4'h3
`define CRBD_BR_CC        4'h4
`define CRBD_BR_HCC       4'h8
`define CRBD_BR_HCS       4'h9
`define CRBD_BR_MC        4'hc
`define CRBD_BR_MS        4'hd
`define CRBD_BR_IL        4'he
`define CRBD_BR_IH        4'hf
`define CRBD_CCR_C        0
`define CRBD_CCR_Z        1
`define CRBD_CCR_N        2
`define CRBD_CCR_I        3
`define CRBD_CCR_H        4
`define CRBD_CYC_IMM      3'h2
`define CRBD_CYC_DIR      3'h3
`define CRBD_CYC_EXT      3'h4
`define CRBD_CYC_IX       3'h3
`define CRBD_CYC_IX1      3'h4
`define CRBD_CYC_IX2      3'h5
`define CRBD_CYC_BR       3'h3
`define CRBD_CCR_RST      5'h08
`endif

// [design/crbd_pkg.sv]
// types shared by the decoder modules
package crbd_pkg;
  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_SBC  = 3'h1,
    ALU_ADC  = 3'h2,
    ALU_EOR  = 3'h3,
    ALU_CMP  = 3'h4,
    ALU_BIT  = 3'h5,
    ALU_ADD  = 3'h6
  } crbd_alu_t;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OPND1 = 3'b001,
    ST_OPND2 = 3'b011,
    ST_EXEC  = 3'b010,
    ST_WAIT  = 3'b110,
    ST_TRAP  = 3'b100
  } crbd_state_t;
endpackage

// [design/crbd_opdecode.sv]
// combinational opcode decode: operation, length, cycles, branch flag
`timescale 1ns/1ps
`include "crbd_defines.svh"
module crbd_opdecode (
  input  wire logic [7:0]        opcode,  // fetched opcode
  output crbd_pkg::crbd_alu_t    aluOp,   // alu operation
  output logic [1:0]             opLen,   // instruction length in bytes
  output logic [2:0]             opCyc,   // total cycle count
  output logic                   isBranch, // relative branch
  output logic                   legal    // opcode handled here
);
  // split opcode into mode (high) and operation (low) nibbles
  always_comb begin
    aluOp    = crbd_pkg::ALU_NONE;
    opLen    = 2'h1;
    opCyc    = 3'h2;
    isBranch = 1'b0;
    legal    = 1'b0;
    unique case (opcode[3:0])
      `CRBD_OP_SBC_LO: aluOp = crbd_pkg::ALU_SBC;
      `CRBD_OP_ADC_LO: aluOp = crbd_pkg::ALU_ADC;
      `CRBD_OP_EOR_LO: aluOp = crbd_pkg::ALU_EOR;
      `CRBD_OP_CMP_LO: aluOp = crbd_pkg::ALU_CMP;
      `CRBD_OP_BIT_LO: aluOp = crbd_pkg::ALU_BIT;
      `CRBD_OP_ADD_LO: aluOp = crbd_pkg::ALU_ADD;
      default:         aluOp = crbd_pkg::ALU_NONE;
    endcase
    if (opcode[7:4] == 4'h2) begin
      // relative branch row, only the conditions this block evaluates
      aluOp = crbd_pkg::ALU_NONE;
      unique case (opcode[3:0])
        `CRBD_BR_HI, `CRBD_BR_LS, `CRBD_BR_CC, `CRBD_BR_HCC, `CRBD_BR_HCS,
        `CRBD_BR_MC, `CRBD_BR_MS, `CRBD_BR_IL, `CRBD_BR_IH: begin
          isBranch = 1'b1;
          legal    = 1'b1;
          opLen    = 2'h2;
          opCyc    = `CRBD_CYC_BR;
        end
        default: legal = 1'b0;
      endcase
    end else if (aluOp != crbd_pkg::ALU_NONE) begin
      // addressing mode sets length and cycle count
      legal = 1'b1;
      unique case (opcode[7:4])
        `CRBD_MODE_IMM: begin
          opLen = 2'h2;
          opCyc = `CRBD_CYC_IMM;
        end
        `CRBD_MODE_DIR: begin
          opLen = 2'h2;
          opCyc = `CRBD_CYC_DIR;
        end
        `CRBD_MODE_EXT: begin
          opLen = 2'h3;
          opCyc = `CRBD_CYC_EXT;
        end
        `CRBD_MODE_IX: begin
          opLen = 2'h1;
          opCyc = `CRBD_CYC_IX;
        end
        `CRBD_MODE_IX1: begin
          opLen = 2'h2;
          opCyc = `CRBD_CYC_IX1;
        end
        `CRBD_MODE_IX2: begin
          opLen = 2'h3;
          opCyc = `CRBD_CYC_IX2;
        end
        default: begin
          legal = 1'b0;
          aluOp = crbd_pkg::ALU_NONE;
        end
      endcase
    end
  end
endmodule

// [design/crbd_alu.sv]
// 8-bit alu for the register/memory group with flag results
`timescale 1ns/1ps
module crbd_alu (
  input  crbd_pkg::crbd_alu_t aluOp,    // operation
  input  wire logic [7:0]     accIn,    // accumulator
  input  wire logic [7:0]     memIn,    // memory operand
  input  wire logic           carryIn,  // current carry flag
  output logic [7:0]          result,   // alu result
  output logic                writeAcc, // result goes back to accumulator
  output logic                halfOut,  // half carry
  output logic                halfUpd,  // half carry updated
  output logic                carryOut, // carry or borrow
  output logic                carryUpd  // carry updated
);
  logic [8:0] wide;  // result with carry bit
  logic [4:0] low;   // low nibble sum for half carry
  always_comb begin
    wide     = 9'h000;
    low      = 5'h00;
    writeAcc = 1'b1;
    halfUpd  = 1'b0;
    carryUpd = 1'b0;
    unique case (aluOp)
      crbd_pkg::ALU_ADD, crbd_pkg::ALU_ADC: begin
        // carry out of bit 3 into bit 4 gives half carry
        low  = {1'b0, accIn[3:0]} + {1'b0, memIn[3:0]}
             + {4'h0, carryIn & (aluOp == crbd_pkg::ALU_ADC)};
        wide = {1'b0, accIn} + {1'b0, memIn}
             + {8'h00, carryIn & (aluOp == crbd_pkg::ALU_ADC)};
        halfUpd  = 1'b1;
        carryUpd = 1'b1;
      end
      crbd_pkg::ALU_SBC, crbd_pkg::ALU_CMP: begin
        // ninth bit is unsigned borrow
        wide = {1'b0, accIn} - {1'b0, memIn}
             - {8'h00, carryIn & (aluOp == crbd_pkg::ALU_SBC)};
        carryUpd = 1'b1;
        writeAcc = (aluOp == crbd_pkg::ALU_SBC);
      end
      crbd_pkg::ALU_EOR: wide = {1'b0, accIn ^ memIn};
      crbd_pkg::ALU_BIT: begin
        wide     = {1'b0, accIn & memIn};
        writeAcc = 1'b0;
      end
      default: writeAcc = 1'b0;
    endcase
    result   = wide[7:0];
    carryOut = wide[8];
    halfOut  = low[4];
  end
endmodule

// [tb/crbd_core_chk.sv]
// port-level checker for the decoder core, bound to crbd_core
`timescale 1ns/1ps
module crbd_core_chk #(
  parameter int unsigned AW = 16  // address width
) (
  input wire logic          clk_sys,   // clock
  input wire logic          arst_n,    // async reset, active low
  input wire logic          clkEn,     // clock enable
  input wire logic          irqPin,    // interrupt pin level
  input wire logic [4:0]    ccrInit,   // flags at reset release
  input wire logic [AW-1:0] pcInit,    // start address
  input wire logic [7:0]    memRdata,  // read data
  input wire logic [7:0]    idxReg,    // index register
  input wire logic [AW-1:0] memAddr,   // memory address
  input wire logic          memRd,     // read strobe
  input wire logic [7:0]    accOut,    // accumulator
  input wire logic [4:0]    ccrOut,    // flags
  input wire logic [AW-1:0] pcOut,     // program counter
  input wire logic          instDone,  // commit pulse
  input wire logic          illegalOp  // trap flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [3:0] gapQ;  // enabled edges since last commit
  logic [3:0] gapD;  // next gap count
  logic       seenQ; // a commit was seen since reset
  logic       seenD; // next seen flag
  // count enabled edges between commits, saturating
  always_comb begin
    gapD = gapQ;
    seenD = seenQ | instDone;
    if (clkEn) begin
      gapD = instDone ? 4'h1 : ((gapQ == 4'hf) ? gapQ : gapQ + 4'h1);
    end
  end
  // register the helper state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gapQ <= 4'h0;
      seenQ <= 1'b0;
    end else begin
      gapQ <= gapD;
      seenQ <= seenD;
    end
  end
  gap_range_a: assert property (instDone && seenQ |-> gapQ >= 4'h2 && gapQ <= 4'h5)
    else $error("instruction spacing outside 2 to 5 cycles");
  done_pulse_a: assert property (instDone && clkEn |=> !instDone)
    else $error("commit pulse longer than one cycle");
  illegal_halt_a: assert property (illegalOp |-> !memRd && !instDone)
    else $error("bus active after trap");
  illegal_sticky_a: assert property (illegalOp |=> illegalOp)
    else $error("trap flag cleared without reset");
  acc_commit_a: assert property ($changed(accOut) |-> instDone)
    else $error("accumulator changed outside a commit");
  ccr_commit_a: assert property ($changed(ccrOut) |-> instDone || $rose(memRd))
    else $error("flags changed outside a commit");
  mask_keep_a: assert property ($changed(ccrOut[3]) |-> $rose(memRd))
    else $error("mask flag altered by an instruction");
  freeze_hold_a: assert property (!clkEn |=> $stable(accOut) && $stable(memAddr)
    && $stable(instDone) && $stable(ccrOut))
    else $error("state moved while clock enable low");
  cover property (instDone && gapQ == 4'h5);
  cover property (instDone && gapQ == 4'h3);
  cover property ($rose(illegalOp));
endmodule
bind crbd_core crbd_core_chk #(.AW(AW)) chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .irqPin(irqPin),
  .ccrInit(ccrInit), .pcInit(pcInit), .memRdata(memRdata), .idxReg(idxReg),
  .memAddr(memAddr), .memRd(memRd), .accOut(accOut), .ccrOut(ccrOut),
  .pcOut(pcOut), .instDone(instDone), .illegalOp(illegalOp));

// [tb/crbd_mem_model.sv]
// zero-wait memory answering the core's fetches and operand reads
`timescale 1ns/1ps
module crbd_mem_model #(
  parameter int unsigned AW = 16  // address width
) (
  input  wire logic          clk_sys,  // clock
  input  wire logic [AW-1:0] memAddr,  // address from the core
  input  wire logic          memRd,    // read strobe
  output logic [7:0]         memRdata  // read data
);
  logic [7:0] memArr [0:255];  // bottom 256 bytes of the map
  logic [7:0] junkQ = 8'h5a;   // changing filler for idle cycles
  // filler moves every cycle so stale data never looks valid
  always_ff @(posedge clk_sys) begin
    junkQ <= junkQ + 8'h3b;
  end
  // answer only while selected and inside the mapped page
  always_comb begin
    if (memRd && (memAddr[AW-1:8] == '0)) begin
      memRdata = memArr[memAddr[7:0]];
    end else begin
      memRdata = ~junkQ;
    end
  end
endmodule

// [tb/tb.sv]
// self-checking bench for the decoder core
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;  // 25 MHz clock
  logic        arst_n = 1'b0;   // reset, active low
  logic        clkEn = 1'b1;    // clock enable
  logic        irqPin = 1'b0;   // interrupt pin
  logic [4:0]  ccrInit = 5'h00; // flags at release
  logic [15:0] pcInit = 16'h0010; // start address
  logic [7:0]  idxReg = 8'h78;  // index value
  logic [7:0]  memRdata;        // read data
  logic [15:0] memAddr;         // address
  logic        memRd;           // read strobe
  logic [7:0]  accOut;          // accumulator
  logic [4:0]  ccrOut;          // flags
  logic [15:0] pcOut;           // program counter
  logic        instDone;        // commit pulse
  logic        illegalOp;       // trap flag
  int          num_errors = 0;  // mismatches
  int          compares = 0;    // comparisons made
  localparam logic [3:0] MHI [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd}; // mode nibbles
  localparam int LEN [6] = '{2, 2, 3, 1, 2, 3};   // bytes per mode
  localparam int CYC [6] = '{2, 3, 4, 3, 4, 5};   // cycles per mode
  localparam logic [7:0] BOP [9] = '{8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h23, 8'h24,
                                     8'h22};
  localparam int BSEL [9] = '{4, 4, 3, 3, 5, 5, 0, 0, 0}; // flag bit, 5 is the pin
  localparam int BWHEN [9] = '{0, 1, 0, 1, 0, 1, 1, 0, 0}; // level that takes it
  always #20 clk_sys = ~clk_sys;
  crbd_core #(.AW(16)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .irqPin(irqPin),
    .ccrInit(ccrInit), .pcInit(pcInit), .memRdata(memRdata), .idxReg(idxReg),
    .memAddr(memAddr), .memRd(memRd), .accOut(accOut), .ccrOut(ccrOut),
    .pcOut(pcOut), .instDone(instDone), .illegalOp(illegalOp));
  crbd_mem_model #(.AW(16)) mem (
    .clk_sys(clk_sys), .memAddr(memAddr), .memRd(memRd), .memRdata(memRdata));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task automatic complete_run;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // write one byte, or wipe memory with an unsupported opcode
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    mem.memArr[a] = b;
  endtask
  task automatic wipe;
    for (int k = 0; k < 256; k++) put(8'(k), 8'h00);
  endtask
  // hold reset 8 cycles, look at reset values, release
  task automatic do_reset(input logic [4:0] ccr);
    @(negedge clk_sys);
    arst_n = 1'b0;
    ccrInit = ccr;
    repeat (8) @(negedge clk_sys);
    check(ccrOut, 16'h0008);
    check({accOut, memRd, instDone}, 16'h0000);
    arst_n = 1'b1;
  endtask
  // enabled cycles up to the next commit, optional freeze mid-way
  task automatic wait_done(input bit frz, output int n);
    n = 0;
    for (int k = 0; k < 30; k++) begin
      @(negedge clk_sys);
      n++;
      if (instDone === 1'b1) return;
      if (frz && n == 1) begin
        clkEn = 1'b0;
        repeat (3) @(negedge clk_sys);
        clkEn = 1'b1;
      end
    end
    num_errors++;
    complete_run();
  endtask
  // expected accumulator and flags for one alu row
  function automatic logic [12:0] ref_alu(input logic [3:0] row, input logic [7:0] a,
                                          input logic [7:0] m, input logic [4:0] c);
    logic [8:0] s;
    logic [4:0] f;
    logic       wr;
    f = c;
    wr = 1'b1;
    case (row)
      4'h2: s = {1'b0, a} - {1'b0, m} - 9'(c[0]);
      4'h1: begin s = {1'b0, a} - {1'b0, m}; wr = 1'b0; end
      4'h9: s = {1'b0, a} + {1'b0, m} + 9'(c[0]);
      4'hb: s = {1'b0, a} + {1'b0, m};
      4'h8: s = {c[0], a ^ m};
      default: begin s = {c[0], a & m}; wr = 1'b0; end
    endcase
    f[0] = s[8];
    if (row == 4'h9 || row == 4'hb) f[4] = ({1'b0, a[3:0]} + {1'b0, m[3:0]}
                                           + 5'((row == 4'h9) & c[0])) > 5'h0f;
    f[1] = (s[7:0] == 8'h00);
    f[2] = s[7];
    return {wr ? s[7:0] : a, f};
  endfunction
  // one alu row through all six modes, preceded by sbc and followed by eor
  task automatic test_alu(input logic [3:0] row);
    int n;
    logic [12:0] e;
    logic [7:0] dat;
    logic [7:0] p;
    for (int i = 0; i < 6; i++) begin
      dat = 8'h0e + 8'(i) * 8'h2c;
      wipe();
      put(8'h10, 8'ha2);
      put(8'h11, 8'h2b);
      put(8'h12, {MHI[i], row});
      case (i)
        0: put(8'h13, dat);
        1: put(8'h13, 8'h80);
        2: begin put(8'h13, 8'h00); put(8'h14, 8'h80); end
        4: put(8'h13, 8'h08);
        5: begin put(8'h13, 8'h00); put(8'h14, 8'h08); end
        default: ;
      endcase
      p = 8'h12 + 8'(LEN[i]);
      put(p, 8'ha8);
      put(p + 8'h01, 8'hff);
      put(8'h78, dat);
      put(8'h80, dat);
      do_reset(5'h00);
      wait_done(1'b0, n);
      e = ref_alu(4'h2, 8'h00, 8'h2b, 5'h00);
      e = ref_alu(row, e[12:5], dat, e[4:0]);
      wait_done(i == 2, n);
      check(16'(n), 16'(CYC[i]));
      check(accOut, e[12:5]);
      check(ccrOut, e[4:0]);
      check(pcOut, 16'(p));
      wait_done(1'b0, n);
      check(16'(n), 16'h0002);
      check({illegalOp, accOut}, {1'b0, ~e[12:5]});
    end
    $display("alu row %h done", row);
  endtask
  // each branch with its condition true and false, negative offset
  task automatic test_branch;
    int n;
    logic [4:0] ccr;
    for (int i = 0; i < 9; i++) begin
      for (int v = 0; v < 2; v++) begin
        wipe();
        put(8'h10, 8'ha8);
        put(8'h11, 8'h01);
        put(8'h12, BOP[i]);
        put(8'h13, 8'hf0);
        put(8'h14, 8'ha8);
        put(8'h15, 8'hff);
        put(8'h04, 8'ha8);
        put(8'h05, 8'h0f);
        ccr = (BSEL[i] < 5) ? 5'(v << BSEL[i]) : 5'h00;
        irqPin = 1'(v);
        do_reset(ccr);
        wait_done(1'b0, n);
        wait_done(1'b0, n);
        check(16'(n), 16'h0003);
        check(ccrOut, ccr);
        check(pcOut, (v == BWHEN[i]) ? 16'h0004 : 16'h0014);
        wait_done(1'b0, n);
        check(accOut, (v == BWHEN[i]) ? 8'h0e : 8'hfe);
      end
    end
    $display("branch group done");
  endtask
  // unsupported opcode traps and leaves the bus idle
  task automatic test_illegal;
    int n;
    wipe();
    put(8'h10, 8'ha8);
    put(8'h11, 8'hff);
    put(8'h12, 8'h9d);
    do_reset(5'h00);
    wait_done(1'b0, n);
    for (int k = 0; k < 10 && illegalOp !== 1'b1; k++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    check({illegalOp, memRd, instDone}, 16'h0004);
    check(accOut, 16'h00ff);
    $display("trap test done");
  endtask
  // main sequence
  initial begin
    test_alu(4'h2);
    test_alu(4'h9);
    test_alu(4'h8);
    test_alu(4'h1);
    test_alu(4'h5);
    test_alu(4'hb);
    test_branch();
    test_illegal();
    complete_run();
  end
endmodule
